// ==== logic/suspend_power_strap_pin.sv ====
`timescale 1ns/1ps
module suspend_power_strap_pin (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  input wire logic mgmt_bus_data_pin,
  input wire logic cfg_sel_pin,
  input wire logic hub_configured,
  input wire logic hub_suspended,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] fixed_port_strap,
  output logic [1:0] fixed_port_mask,
  output logic self_powered
);

  strap_pkg::state_t state;
  strap_pkg::state_t next_state;
  logic mgmt_mode;
  logic next_mgmt_mode;
  logic [1:0] next_fixed_port_strap;
  logic sampled_power;
  logic next_sampled_power;
  logic [1:0] config_byte_two_reg;
  logic [1:0] next_config_byte_two_reg;
  logic status_command_reg;
  logic next_status_command_reg;
  logic ack;
  logic next_ack;
  logic [31:0] next_readdata;
  logic next_pin_out;
  logic next_self_powered;
  logic indicator;
  logic dynamic_en;
  logic attached;

  assign dynamic_en = config_byte_two_reg[strap_pkg::CONFIG_DYNAMIC_BIT];
  assign attached = status_command_reg;
  assign indicator = hub_configured & ~hub_suspended;
  assign fixed_port_mask = strap_pkg::fixed_mask(fixed_port_strap);
  // Pin is only driven as indicator in strap mode after capture
  assign pin_oe = (state == strap_pkg::ST_STRAP_RUN);
  assign waitrequest = (read | write) & ~ack;

  // Mode, straps and power sample
  always_comb begin
    next_state = state;
    next_mgmt_mode = mgmt_mode;
    next_fixed_port_strap = fixed_port_strap;
    next_sampled_power = sampled_power;
    case (state)
      strap_pkg::ST_CAPTURE: begin
        next_mgmt_mode = (cfg_sel_pin == strap_pkg::CFG_SEL_MGMT);
        next_fixed_port_strap = {mgmt_bus_data_pin, pin_in};
        next_sampled_power = pin_in;
        if (cfg_sel_pin == strap_pkg::CFG_SEL_MGMT) begin
          next_state = strap_pkg::ST_MGMT_RUN;
        end else begin
          next_state = strap_pkg::ST_STRAP_RUN;
        end
      end
      strap_pkg::ST_MGMT_RUN: begin
        // High level means a local supply is present
        if (!attached) begin
          next_sampled_power = pin_in;
        end
      end
      strap_pkg::ST_STRAP_RUN: begin
        next_state = strap_pkg::ST_STRAP_RUN;
      end
      default: begin
        next_state = strap_pkg::ST_CAPTURE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= strap_pkg::ST_CAPTURE;
      mgmt_mode <= 1'b0;
      fixed_port_strap <= strap_pkg::STRAP_RESET;
      sampled_power <= 1'b0;
    end else begin
      state <= next_state;
      mgmt_mode <= next_mgmt_mode;
      fixed_port_strap <= next_fixed_port_strap;
      sampled_power <= next_sampled_power;
    end
  end

  // Pin and report outputs
  always_comb begin
    next_pin_out = 1'b0;
    if (state == strap_pkg::ST_STRAP_RUN) begin
      next_pin_out = indicator;
    end
    next_self_powered = config_byte_two_reg[strap_pkg::CONFIG_SELF_BIT];
    if (mgmt_mode && dynamic_en) begin
      next_self_powered = sampled_power;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pin_out <= 1'b0;
      self_powered <= 1'b0;
    end else begin
      pin_out <= next_pin_out;
      self_powered <= next_self_powered;
    end
  end

  // Avalon-MM slave: one wait cycle, data ready at the release
  always_comb begin
    next_ack = (read | write) & ~ack;
    next_config_byte_two_reg = config_byte_two_reg;
    next_status_command_reg = status_command_reg;
    next_readdata = readdata;
    if (write && ack) begin
      case (address)
        strap_pkg::ADDR_CONFIG_TWO: begin
          next_config_byte_two_reg = writedata[1:0];
        end
        strap_pkg::ADDR_STATUS_CMD: begin
          // Attach lock can be set by software, cleared only by reset
          if (writedata[strap_pkg::STATUS_ATTACH_BIT]) begin
            next_status_command_reg = 1'b1;
          end
        end
        default: begin
          next_status_command_reg = status_command_reg;
        end
      endcase
    end
    if (read && !ack) begin
      next_readdata = 32'h0;
      case (address)
        strap_pkg::ADDR_CONFIG_TWO: begin
          next_readdata[1:0] = config_byte_two_reg;
        end
        strap_pkg::ADDR_STATUS_CMD: begin
          next_readdata[strap_pkg::STATUS_ATTACH_BIT] = status_command_reg;
        end
        strap_pkg::ADDR_STRAP: begin
          next_readdata[strap_pkg::STRAP_VALUE_LSB +: 2] = fixed_port_strap;
          next_readdata[strap_pkg::STRAP_MASK_LSB +: 2] = fixed_port_mask;
          next_readdata[strap_pkg::STRAP_RESERVED_BIT] =
            (fixed_port_strap == strap_pkg::STRAP_RESERVED);
          next_readdata[strap_pkg::STRAP_MGMT_BIT] = mgmt_mode;
          next_readdata[strap_pkg::STRAP_POWER_BIT] = sampled_power;
        end
        strap_pkg::ADDR_HUB: begin
          next_readdata[strap_pkg::HUB_CONFIGURED_BIT] = hub_configured;
          next_readdata[strap_pkg::HUB_SUSPENDED_BIT] = hub_suspended;
          next_readdata[strap_pkg::HUB_INDICATOR_BIT] = pin_out;
          next_readdata[strap_pkg::HUB_REPORT_BIT] = self_powered;
        end
        default: begin
          next_readdata = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ack <= 1'b0;
      config_byte_two_reg <= strap_pkg::CONFIG_TWO_RESET;
      status_command_reg <= strap_pkg::STATUS_CMD_RESET;
      readdata <= 32'h0;
    end else begin
      ack <= next_ack;
      config_byte_two_reg <= next_config_byte_two_reg;
      status_command_reg <= next_status_command_reg;
      readdata <= next_readdata;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence capture_cycle;
    state == strap_pkg::ST_CAPTURE;
  endsequence

  sequence strap_running;
    state == strap_pkg::ST_STRAP_RUN;
  endsequence

  sequence mgmt_running;
    state == strap_pkg::ST_MGMT_RUN;
  endsequence

  chk_susp_negated: assert property (
    strap_running and (!hub_configured || hub_suspended) |=> !pin_out)
    else $error("indicator high while unconfigured or suspended");

  chk_susp_asserted: assert property (
    strap_running and hub_configured && !hub_suspended |=> pin_out)
    else $error("indicator low while configured and active");

  chk_dynamic_report: assert property (
    mgmt_mode && dynamic_en && $stable(sampled_power)
      |=> self_powered == $past(sampled_power))
    else $error("power report does not follow sensed value");

  chk_power_frozen: assert property (
    attached && $past(attached) |-> $stable(sampled_power))
    else $error("power sample changed after attach");

  chk_power_level: assert property (
    state == strap_pkg::ST_MGMT_RUN && !attached
      |=> sampled_power == $past(pin_in))
    else $error("power sample does not match pin level");

  chk_pin_released: assert property (
    mgmt_mode |-> !pin_oe && !pin_out)
    else $error("pin driven in management mode");

  chk_strap_drive: assert property (
    capture_cycle ##1 !mgmt_mode |-> pin_oe)
    else $error("strap mode does not drive indicator");

  chk_strap_capture: assert property (
    capture_cycle |=> fixed_port_strap == {$past(mgmt_bus_data_pin),
      $past(pin_in)} && sampled_power == $past(pin_in))
    else $error("strap not captured at release");

  chk_strap_decode: assert property (
    fixed_port_strap == strap_pkg::STRAP_PORTS12_FIXED
      |-> fixed_port_mask == 2'h3)
    else $error("strap 10 does not fix both ports");

  chk_cfg_latch: assert property (
    capture_cycle |=> mgmt_mode == $past(cfg_sel_pin)
      ##1 (state != strap_pkg::ST_CAPTURE))
    else $error("configuration select not latched");

  chk_strap_hold: assert property (
    !(state == strap_pkg::ST_CAPTURE) [*2]
      |-> $stable(fixed_port_strap) && $stable(mgmt_mode))
    else $error("captured strap changed before reset");

  chk_bus_wait: assert property (
    (read || write) && !ack |-> waitrequest ##1 !waitrequest)
    else $error("slave answer not after one wait cycle");

  chk_idle_no_wait: assert property (
    !(read || write) |-> !waitrequest)
    else $error("wait asserted with no request");

  chk_strap_release: assert property (
    capture_cycle |-> !pin_oe)
    else $error("pin driven while straps are sampled");

  chk_strap_port1: assert property (
    fixed_port_strap == strap_pkg::STRAP_PORT1_FIXED
      |-> fixed_port_mask == 2'h1)
    else $error("strap 01 does not fix port 1 only");

  chk_strap_removable: assert property (
    fixed_port_strap == strap_pkg::STRAP_ALL_REMOVABLE
      || fixed_port_strap == strap_pkg::STRAP_RESERVED
      |-> fixed_port_mask == 2'h0)
    else $error("strap 00 or 11 marks a fixed port");

  chk_static_report: assert property (
    !mgmt_mode
      |=> self_powered == $past(config_byte_two_reg[1]))
    else $error("strap mode report does not follow static bit");

  chk_attach_sticky: assert property (
    attached |=> attached)
    else $error("attach lock cleared without reset");

  chk_power_hold: assert property (
    mgmt_running ##0 attached |=> $stable(sampled_power))
    else $error("power sample moved while attached");

  chk_mgmt_state: assert property (
    mgmt_mode |-> state == strap_pkg::ST_MGMT_RUN)
    else $error("management mode outside management run");

endmodule

// ==== logic/strap_pkg.sv ====
package strap_pkg;
  // Register byte offsets on the management slave
  localparam logic [3:0] ADDR_CONFIG_TWO = 4'h0;
  localparam logic [3:0] ADDR_STATUS_CMD = 4'h4;
  localparam logic [3:0] ADDR_STRAP = 4'h8;
  localparam logic [3:0] ADDR_HUB = 4'hc;
  // Field positions
  localparam int CONFIG_DYNAMIC_BIT = 0;
  localparam int CONFIG_SELF_BIT = 1;
  localparam int STATUS_ATTACH_BIT = 0;
  localparam int STRAP_VALUE_LSB = 0;
  localparam int STRAP_MASK_LSB = 2;
  localparam int STRAP_RESERVED_BIT = 4;
  localparam int STRAP_MGMT_BIT = 5;
  localparam int STRAP_POWER_BIT = 6;
  localparam int HUB_CONFIGURED_BIT = 0;
  localparam int HUB_SUSPENDED_BIT = 1;
  localparam int HUB_INDICATOR_BIT = 2;
  localparam int HUB_REPORT_BIT = 3;
  // Values after reset
  localparam logic [1:0] CONFIG_TWO_RESET = 2'h0;
  localparam logic STATUS_CMD_RESET = 1'b0;
  localparam logic [1:0] STRAP_RESET = 2'h0;
  // Configuration select level that means management-bus setup
  localparam logic CFG_SEL_MGMT = 1'b1;
  // Fixed-port strap codes
  localparam logic [1:0] STRAP_ALL_REMOVABLE = 2'h0;
  localparam logic [1:0] STRAP_PORT1_FIXED = 2'h1;
  localparam logic [1:0] STRAP_PORTS12_FIXED = 2'h2;
  localparam logic [1:0] STRAP_RESERVED = 2'h3;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_MIN_NS = 1000;
  localparam int RESET_MIN_CYCLES =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_CAPTURE = 3'h1,
    ST_STRAP_RUN = 3'h2,
    ST_MGMT_RUN = 3'h4
  } state_t;

  // Mask of fixed ports, bit 1 = port 2, bit 0 = port 1
  function automatic logic [1:0] fixed_mask(input logic [1:0] strap);
    case (strap)
      STRAP_PORT1_FIXED: fixed_mask = 2'h1;
      STRAP_PORTS12_FIXED: fixed_mask = 2'h3;
      default: fixed_mask = 2'h0;
    endcase
  endfunction
endpackage

// ==== tb/board_model.sv ====
`timescale 1ns/1ps
// Board side of the pin: strap resistor or power sense when the pin is free
module board_model (
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic board_level,
  output logic pin_in
);
  // A driven pin shows the hub's own value, a free one the board level
  assign pin_in = pin_oe ? pin_out : board_level;
endmodule

// ==== tb/test_suspend_power_strap_pin.sv ====
`timescale 1ns/1ps
module test_suspend_power_strap_pin;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic pin_in, pin_out, pin_oe, board_level = 1'b0;
  logic mgmt_bus_data_pin = 1'b0, cfg_sel_pin = 1'b0;
  logic hub_configured = 1'b0, hub_suspended = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0, write = 1'b0;
  logic [31:0] writedata = 32'h0, readdata;
  logic waitrequest, self_powered;
  logic [1:0] fixed_port_strap, fixed_port_mask;
  int bad_count = 0;
  int n_compared = 0;

  always #50 clk_sys = ~clk_sys;

  suspend_power_strap_pin i_dut (.clk_sys(clk_sys), .reset(reset),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .mgmt_bus_data_pin(mgmt_bus_data_pin), .cfg_sel_pin(cfg_sel_pin),
    .hub_configured(hub_configured), .hub_suspended(hub_suspended),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .fixed_port_strap(fixed_port_strap),
    .fixed_port_mask(fixed_port_mask), .self_powered(self_powered));

  board_model i_board (.pin_out(pin_out), .pin_oe(pin_oe),
    .board_level(board_level), .pin_in(pin_in));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // One Avalon transfer, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    address <= a;
    writedata <= wd;
    read <= ~wr;
    write <= wr;
    @(posedge clk_sys);
    while (waitrequest !== 1'b0) begin
      @(posedge clk_sys);
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic do_reset(input logic cfg, input logic msb, input logic lvl);
    cfg_sel_pin <= cfg;
    mgmt_bus_data_pin <= msb;
    board_level <= lvl;
    reset <= 1'b1;
    tick(10);
    reset <= 1'b0;
    tick(3);
  endtask

  task automatic strap_case(input logic [1:0] code, input logic [1:0] mask);
    logic [31:0] d;
    do_reset(1'b0, code[1], code[0]);
    check(fixed_port_strap, code);
    check(fixed_port_mask, mask);
    check(pin_oe, 1'b1);
    bus(1'b0, strap_pkg::ADDR_STRAP, 32'h0, d);
    check(d[5:0], {1'b0, code == 2'h3, mask, code});
    mgmt_bus_data_pin <= ~code[1];
    board_level <= ~code[0];
    tick(3);
    check(fixed_port_strap, code);
  endtask

  task automatic indicator_case;
    logic [31:0] d;
    do_reset(1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      hub_configured <= i[1];
      hub_suspended <= i[0];
      tick(3);
      check(pin_out, i == 2);
      check(pin_in, i == 2);
    end
    bus(1'b0, strap_pkg::ADDR_HUB, 32'h0, d);
    check(d, 32'h3);
    bus(1'b1, strap_pkg::ADDR_CONFIG_TWO, 32'h1, d);
    board_level <= 1'b1;
    tick(3);
    check(self_powered, 1'b0);
  endtask

  task automatic mgmt_case;
    logic [31:0] d;
    do_reset(1'b1, 1'b0, 1'b1);
    check(pin_oe, 1'b0);
    bus(1'b0, strap_pkg::ADDR_STRAP, 32'h0, d);
    check(d[6:5], 2'h3);
    check(self_powered, 1'b0);
    bus(1'b1, strap_pkg::ADDR_CONFIG_TWO, 32'h1, d);
    tick(2);
    check(self_powered, 1'b1);
    board_level <= 1'b0;
    tick(3);
    check(self_powered, 1'b0);
    board_level <= 1'b1;
    tick(3);
    check(self_powered, 1'b1);
    bus(1'b1, strap_pkg::ADDR_STATUS_CMD, 32'h1, d);
    board_level <= 1'b0;
    tick(3);
    check(self_powered, 1'b1);
    bus(1'b0, strap_pkg::ADDR_STATUS_CMD, 32'h0, d);
    check(d, 32'h1);
    bus(1'b0, 4'h2, 32'h0, d);
    check(d, 32'h0);
    bus(1'b1, strap_pkg::ADDR_CONFIG_TWO, 32'h0, d);
    tick(2);
    check(self_powered, 1'b0);
  endtask

  task automatic wrap_up;
    if (bad_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    tick(2);
    reset <= 1'b0;
    tick(1);
    strap_case(2'h0, 2'h0);
    strap_case(2'h1, 2'h1);
    strap_case(2'h2, 2'h3);
    strap_case(2'h3, 2'h0);
    indicator_case();
    mgmt_case();
    wrap_up();
  end

  initial begin
    #2000000;
    bad_count++;
    wrap_up();
  end
endmodule
